/* rtl/mmp_pkg.sv */
// Shared constants and types for the management port.
package mmp_pkg;
	localparam logic [7:0] ADDR_CTL = 8'h30;
	localparam logic [7:0] ADDR_DATA = 8'h34;
	localparam logic [7:0] ADDR_CFG = 8'h38;
	localparam int CTL_PHY_LSB = 9;
	localparam int CTL_REG_LSB = 4;
	localparam int CTL_WRITE = 1;
	localparam int CTL_READ = 0;
	localparam int CFG_CLK_SRC = 15;
	localparam int CFG_CLK_SEL = 14;
	localparam int CFG_DIR_IN = 7;
	localparam int CFG_ALT_DATA = 6;
	localparam int CFG_ALT_CLK = 5;
	localparam int CFG_SERIAL_EN = 4;
	localparam int CFG_XCVR_EN = 1;
	localparam int CFG_SERIAL_MODE = 0;
	localparam logic CFG_SERIAL_EN_RESET = 1'h1;
	localparam logic [15:0] DATA_RESET = 16'h0000;
	localparam int CLK_PERIOD_NS = 10;
	localparam int MDC_HALF_NS = 200;
	localparam int MDC_HALF_CYCLES = (MDC_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [4:0] MDC_HALF_LAST = 5'(MDC_HALF_CYCLES - 1);
	localparam logic [12:0] FRAME_CYCLES = 13'(64 * 2 * MDC_HALF_CYCLES);
	localparam logic [5:0] BIT_PHY_MSB = 6'h24;
	localparam logic [5:0] BIT_REG_MSB = 6'h29;
	localparam logic [5:0] BIT_TA = 6'h2E;
	localparam logic [5:0] BIT_TA2 = 6'h2F;
	localparam logic [5:0] BIT_LAST = 6'h3F;
	localparam logic [31:0] PREAMBLE = 32'hFFFFFFFF;
	localparam logic [1:0] START_CODE = 2'h1;
	localparam logic [1:0] OP_READ = 2'h2;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] TA_WRITE = 2'h2;
	typedef enum logic [1:0] {PH_IDLE, PH_LOW, PH_HIGH} mmp_phase_type;
endpackage : mmp_pkg

/* rtl/mmp_frame_if.sv */
// Signals between the register side and the frame engine.
`timescale 1ns/1ps
`default_nettype none
interface mmp_frame_if;
	logic start;
	logic is_write;
	logic [4:0] phy;
	logic [4:0] regad;
	logic [15:0] wdata;
	logic mdio_i;
	logic busy;
	logic done;
	logic resp;
	logic [15:0] rdata;
	logic mdc;
	logic mdio_o;
	logic mdio_oe;
	modport engine (input start, is_write, phy, regad, wdata, mdio_i,
		output busy, done, resp, rdata, mdc, mdio_o, mdio_oe);
	modport ctrl (output start, is_write, phy, regad, wdata, mdio_i,
		input busy, done, resp, rdata, mdc, mdio_o, mdio_oe);
endinterface : mmp_frame_if
`default_nettype wire

/* rtl/mmp_sync.sv */
// Two-stage synchroniser for pin inputs.
`timescale 1ns/1ps
`default_nettype none
module mmp_sync #(
	parameter int WIDTH = 2
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] sync;
	} mmp_sync_state_type;
	mmp_sync_state_type st;
	mmp_sync_state_type next_st;
	always_comb begin
		next_st.meta = d;
		next_st.sync = st.meta;
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
	assign q = st.sync;
endmodule : mmp_sync
`default_nettype wire

/* rtl/mmp_frame_engine.sv */
// Serial management frame engine with divided management clock.
`timescale 1ns/1ps
`default_nettype none
module mmp_frame_engine (
	input wire logic clk,
	input wire logic rst_n,
	mmp_frame_if.engine fb
);
	typedef struct packed {
		mmp_pkg::mmp_phase_type phase;
		logic [4:0] cnt;
		logic [5:0] bit_idx;
		logic [63:0] frame;
		logic is_write;
		logic [4:0] phy;
		logic [4:0] regad;
		logic [15:0] rdata;
		logic resp;
		logic mdc;
		logic mdio_o;
		logic mdio_oe;
		logic done;
		logic busy;
	} mmp_eng_state_type;
	mmp_eng_state_type st;
	mmp_eng_state_type next_st;
	logic [12:0] busy_cycles;

	function automatic logic [63:0] build_frame(input logic wr, input logic [4:0] phy,
		input logic [4:0] regad, input logic [15:0] data);
		build_frame = {mmp_pkg::PREAMBLE, mmp_pkg::START_CODE,
			wr ? mmp_pkg::OP_WRITE : mmp_pkg::OP_READ, phy, regad,
			wr ? mmp_pkg::TA_WRITE : 2'h0, wr ? data : 16'h0000};
	endfunction : build_frame

	always_comb begin
		next_st = st;
		next_st.done = 1'b0;
		case (st.phase)
			mmp_pkg::PH_IDLE: begin
				if (fb.start) begin
					next_st.phase = mmp_pkg::PH_LOW;
					next_st.cnt = 5'h00;
					next_st.bit_idx = 6'h00;
					next_st.frame = build_frame(fb.is_write, fb.phy, fb.regad, fb.wdata); // [RULE_19]
					next_st.is_write = fb.is_write;
					next_st.phy = fb.phy;
					next_st.regad = fb.regad;
					next_st.resp = 1'b0;
					next_st.busy = 1'b1;
					next_st.mdc = 1'b0;
					next_st.mdio_o = 1'b1;
					next_st.mdio_oe = 1'b1;
				end
			end
			mmp_pkg::PH_LOW: begin
				next_st.cnt = st.cnt + 5'h01;
				if (st.cnt == mmp_pkg::MDC_HALF_LAST) begin
					next_st.cnt = 5'h00;
					next_st.phase = mmp_pkg::PH_HIGH;
					next_st.mdc = 1'b1;
					if (!st.is_write && st.bit_idx == mmp_pkg::BIT_TA2) begin
						next_st.resp = !fb.mdio_i; // [RULE_06]
					end
					if (!st.is_write && st.bit_idx > mmp_pkg::BIT_TA2) begin
						next_st.rdata = {st.rdata[14:0], fb.mdio_i}; // [RULE_05]
					end
				end
			end
			mmp_pkg::PH_HIGH: begin
				next_st.cnt = st.cnt + 5'h01;
				if (st.cnt == mmp_pkg::MDC_HALF_LAST) begin
					next_st.cnt = 5'h00;
					next_st.mdc = 1'b0;
					if (st.bit_idx == mmp_pkg::BIT_LAST) begin
						next_st.phase = mmp_pkg::PH_IDLE;
						next_st.done = 1'b1;
						next_st.busy = 1'b0;
						next_st.mdio_oe = 1'b0;
					end else begin
						next_st.phase = mmp_pkg::PH_LOW;
						next_st.bit_idx = st.bit_idx + 6'h01;
						next_st.frame = {st.frame[62:0], 1'b0};
						next_st.mdio_o = st.frame[62]; // [RULE_01] [RULE_02] [RULE_04]
						next_st.mdio_oe = st.is_write || (st.bit_idx + 6'h01 < mmp_pkg::BIT_TA); // [RULE_05]
					end
				end
			end
			default: begin
				next_st.phase = mmp_pkg::PH_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign fb.busy = st.busy;
	assign fb.done = st.done;
	assign fb.resp = st.resp;
	assign fb.rdata = st.rdata;
	assign fb.mdc = st.mdc;
	assign fb.mdio_o = st.mdio_o;
	assign fb.mdio_oe = st.mdio_oe;

	// Counts the length of each frame so that the clock divider can be checked.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			busy_cycles <= 13'h0000;
		end else if (st.busy) begin
			busy_cycles <= busy_cycles + 13'h0001;
		end else begin
			busy_cycles <= 13'h0000;
		end
	end

	AST_FRAME_LEN: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_19]
		$fell(st.busy) |-> busy_cycles == mmp_pkg::FRAME_CYCLES)
		else $error("Frame length differs from 64 clock periods.");
	AST_PREAMBLE: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_19]
		(st.busy && st.bit_idx < 6'h20) |-> (st.mdio_o && st.mdio_oe))
		else $error("Preamble bit not driven high.");
	AST_PHY_MSB: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_01]
		(st.phase == mmp_pkg::PH_HIGH && st.bit_idx == mmp_pkg::BIT_PHY_MSB)
		|-> st.mdio_o == st.phy[4])
		else $error("PHY address MSB not sent in its slot.");
	AST_REG_MSB: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_02]
		(st.phase == mmp_pkg::PH_HIGH && st.bit_idx == mmp_pkg::BIT_REG_MSB)
		|-> st.mdio_o == st.regad[4])
		else $error("Register address MSB not sent in its slot.");
	AST_READ_RELEASE: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_05]
		(st.busy && !st.is_write && st.bit_idx >= mmp_pkg::BIT_TA) |-> !st.mdio_oe)
		else $error("Data line driven during read turnaround or data.");
	AST_RESPONDER: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_06]
		(st.phase == mmp_pkg::PH_LOW && st.cnt == mmp_pkg::MDC_HALF_LAST && !st.is_write
		&& st.bit_idx == mmp_pkg::BIT_TA2) |=> st.resp == !$past(fb.mdio_i))
		else $error("Responder sample wrong.");
endmodule : mmp_frame_engine
`default_nettype wire

/* rtl/mmp_top.sv */
// Management port registers, pin muxing and frame engine.
// Notes on behaviour
// [RULE_01] Frame carries five-bit PHY address from control bits 13..9, MSB first.
// [RULE_02] Frame carries five-bit register address from control bits 8..4, MSB first.
// [RULE_03] Software sets an operation bit; hardware clears it when the frame ends.
// [RULE_04] Control bit 1 sends a write frame using the data register value.
// [RULE_05] Control bit 0 sends a read frame and shifts returned bits into data.
// [RULE_06] Responder bit 3 set when PHY drives zero in second turnaround cycle.
// [RULE_07] Responder bit clears after software reads the control register.
// [RULE_08] Data register holds 16 bits: write source and read result.
// [RULE_09] Config bit 4 selects engine or software pin control; resets to one.
// [RULE_10] With engine off, config bit 7 makes the data pin an input.
// [RULE_11] Config bit 6 reads the data pin; written value drives it when output.
// [RULE_12] With engine off, config bit 5 drives the management clock pin.
// [RULE_13] Config bit 3 reads one when the data line is high.
// [RULE_14] Config bit 2 returns the transceiver link pin level.
// [RULE_15] Config bit 1 drives the transceiver enable pin.
// [RULE_16] Config bit 0 selects the seven-wire serial MII mode.
// [RULE_17] With config bit 14 set, bit 15 selects internal system clock for transmit.
// [RULE_18] Config bit 0 clear keeps the standard nibble-wide MII.
// [RULE_19] Frames use clause 22 format with clock divided from the system clock.
// [RULE_20] Software waits for the operation bit to clear before next access.
`timescale 1ns/1ps
`default_nettype none
module mmp_top (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_wdata,
	output logic [31:0] reg_rdata,
	output logic reg_rvalid,
	output logic serial_mgmt_clock,
	input wire logic mgmt_data_in,
	output logic mgmt_data_out,
	output logic mgmt_data_oe,
	input wire logic transceiver_link_pin,
	output logic transceiver_enable_pin,
	output logic mii_serial_mode,
	output logic tx_clock_use_internal_system_clock
);
	typedef struct packed {
		logic [4:0] phy;
		logic [4:0] regad;
		logic resp;
		logic op_write;
		logic op_read;
		logic start;
		logic [15:0] data;
		logic clk_src;
		logic clk_sel;
		logic dir_in;
		logic alt_data;
		logic alt_clk;
		logic serial_en;
		logic xcvr_en;
		logic serial_mode;
		logic [31:0] rdata;
		logic rvalid;
		logic mdc_pin;
		logic mdio_o;
		logic mdio_oe;
		logic xcvr_pin;
		logic mode_pin;
		logic internal_system_clock_pin;
	} mmp_top_state_type;

	mmp_top_state_type st;
	mmp_top_state_type next_st;
	logic [1:0] pins_sync;
	logic mdio_level;
	logic link_level;
	logic busy_any;
	logic hit_ctl;
	logic hit_data;
	logic hit_cfg;
	logic [12:0] run_cnt;

	mmp_frame_if frame_bus ();

	mmp_sync #(
		.WIDTH(2)
	) u_sync (
		.clk(clk),
		.rst_n(rst_n),
		.d({transceiver_link_pin, mgmt_data_in}),
		.q(pins_sync)
	);

	mmp_frame_engine u_engine (
		.clk(clk),
		.rst_n(rst_n),
		.fb(frame_bus.engine)
	);

	assign mdio_level = pins_sync[0];
	assign link_level = pins_sync[1];
	assign busy_any = st.op_write || st.op_read;
	assign hit_ctl = reg_addr == mmp_pkg::ADDR_CTL;
	assign hit_data = reg_addr == mmp_pkg::ADDR_DATA;
	assign hit_cfg = reg_addr == mmp_pkg::ADDR_CFG;

	assign frame_bus.start = st.start;
	assign frame_bus.is_write = st.op_write;
	assign frame_bus.phy = st.phy;
	assign frame_bus.regad = st.regad;
	assign frame_bus.wdata = st.data;
	assign frame_bus.mdio_i = mdio_level;

	always_comb begin
		next_st = st;
		next_st.start = 1'b0;
		// Control writes are dropped mid-frame so the fields on the wire stay stable.
		if (reg_wr && hit_ctl && !busy_any) begin
			next_st.phy = reg_wdata[mmp_pkg::CTL_PHY_LSB +: 5];
			next_st.regad = reg_wdata[mmp_pkg::CTL_REG_LSB +: 5];
			next_st.op_write = reg_wdata[mmp_pkg::CTL_WRITE]; // [RULE_04]
			next_st.op_read = reg_wdata[mmp_pkg::CTL_READ] && !reg_wdata[mmp_pkg::CTL_WRITE];
			next_st.start = reg_wdata[mmp_pkg::CTL_WRITE] || reg_wdata[mmp_pkg::CTL_READ];
		end
		if (reg_wr && hit_data && !busy_any) begin
			next_st.data = reg_wdata[15:0]; // [RULE_08]
		end
		if (reg_wr && hit_cfg) begin
			next_st.clk_src = reg_wdata[mmp_pkg::CFG_CLK_SRC];
			next_st.clk_sel = reg_wdata[mmp_pkg::CFG_CLK_SEL];
			next_st.dir_in = reg_wdata[mmp_pkg::CFG_DIR_IN];
			next_st.alt_data = reg_wdata[mmp_pkg::CFG_ALT_DATA];
			next_st.alt_clk = reg_wdata[mmp_pkg::CFG_ALT_CLK];
			next_st.serial_en = reg_wdata[mmp_pkg::CFG_SERIAL_EN];
			next_st.xcvr_en = reg_wdata[mmp_pkg::CFG_XCVR_EN];
			next_st.serial_mode = reg_wdata[mmp_pkg::CFG_SERIAL_MODE];
		end
		if (reg_rd && hit_ctl) begin
			next_st.resp = 1'b0; // [RULE_07]
		end
		if (frame_bus.done) begin
			next_st.op_write = 1'b0; // [RULE_03]
			next_st.op_read = 1'b0;
			if (st.op_read) begin
				next_st.data = frame_bus.rdata; // [RULE_05] [RULE_08]
				// A responder event wins over a clear in the same cycle.
				next_st.resp = next_st.resp || frame_bus.resp; // [RULE_06]
			end
		end
		next_st.rvalid = reg_rd;
		next_st.rdata = 32'h00000000;
		if (reg_rd && hit_ctl) begin
			next_st.rdata = {18'h00000, st.phy, st.regad, st.resp, 1'b0, st.op_write, st.op_read};
		end else if (reg_rd && hit_data) begin
			next_st.rdata = {16'h0000, st.data};
		end else if (reg_rd && hit_cfg) begin
			next_st.rdata = {16'h0000, st.clk_src, st.clk_sel, 6'h00, st.dir_in,
				mdio_level, st.alt_clk, st.serial_en, mdio_level, // [RULE_11] [RULE_13]
				link_level, st.xcvr_en, st.serial_mode}; // [RULE_14]
		end
		if (st.serial_en) begin // [RULE_09]
			next_st.mdc_pin = frame_bus.mdc;
			next_st.mdio_o = frame_bus.mdio_o;
			next_st.mdio_oe = frame_bus.mdio_oe;
		end else begin
			next_st.mdc_pin = st.alt_clk; // [RULE_12]
			next_st.mdio_o = st.alt_data; // [RULE_11]
			next_st.mdio_oe = !st.dir_in; // [RULE_10]
		end
		next_st.xcvr_pin = st.xcvr_en; // [RULE_15]
		next_st.mode_pin = st.serial_mode; // [RULE_16] [RULE_18]
		// The actual clock mux sits in the transmit clock tree; this only steers it.
		next_st.internal_system_clock_pin = st.clk_sel && st.clk_src; // [RULE_17]
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
			st.serial_en <= mmp_pkg::CFG_SERIAL_EN_RESET; // [RULE_09]
			st.data <= mmp_pkg::DATA_RESET;
		end else begin
			st <= next_st;
		end
	end

	// Counts busy cycles so that a hung frame is caught without a long delay range.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			run_cnt <= 13'h0000;
		end else if (frame_bus.busy) begin
			run_cnt <= run_cnt + 13'h0001;
		end else begin
			run_cnt <= 13'h0000;
		end
	end

	assign reg_rdata = st.rdata;
	assign reg_rvalid = st.rvalid;
	assign serial_mgmt_clock = st.mdc_pin;
	assign mgmt_data_out = st.mdio_o;
	assign mgmt_data_oe = st.mdio_oe;
	assign transceiver_enable_pin = st.xcvr_pin;
	assign mii_serial_mode = st.mode_pin;
	assign tx_clock_use_internal_system_clock = st.internal_system_clock_pin;

	AST_OP_CLEARS: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_03]
		frame_bus.done |=> !st.op_write && !st.op_read)
		else $error("Operation bit not cleared after frame.");
	AST_START_RUNS: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_03]
		st.start |=> frame_bus.busy)
		else $error("Started frame did not run.");
	AST_RUN_BOUND: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_03]
		frame_bus.busy |-> run_cnt < mmp_pkg::FRAME_CYCLES)
		else $error("Frame ran past its length.");
	AST_RESP_CLEAR: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_07]
		(reg_rd && hit_ctl && !frame_bus.done) |=> !st.resp)
		else $error("Responder not cleared by control read.");
	AST_READ_DATA: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_05]
		(frame_bus.done && st.op_read) |=> st.data == $past(frame_bus.rdata))
		else $error("Read data not stored.");
	AST_ALT_CLOCK: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_12]
		!st.serial_en |=> serial_mgmt_clock == $past(st.alt_clk))
		else $error("Direct clock bit not on pin.");
	AST_DIR_INPUT: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_10]
		(!st.serial_en && st.dir_in) |=> !mgmt_data_oe)
		else $error("Data pin driven while set as input.");
	AST_XCVR_EN: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_15]
		(reg_wr && hit_cfg) |=> ##1 transceiver_enable_pin == $past(reg_wdata[1], 2))
		else $error("Transceiver enable pin does not follow bit.");
endmodule : mmp_top
`default_nettype wire

/* verification/mmp_phy_model.sv */
// Behavioural transceiver on the management lines with a small register file.
`timescale 1ns/1ps
`default_nettype none
module mmp_phy_model #(
	parameter logic [4:0] PHY_ADDR = 5'h15
) (
	input wire logic mdc,
	input wire logic dev_out,
	input wire logic dev_oe,
	input wire logic hold_low,
	output logic line,
	output logic [63:0] last_frame
);
	logic [63:0] sh;
	logic [15:0] mem [0:31];
	logic [15:0] rd;
	logic rd_go;
	logic phy_oe;
	logic phy_out;
	int pos;
	// The line has a pull-up, so a released line reads high unless hold_low pulls it low, instead of the last value.
	assign line = dev_oe ? dev_out : (phy_oe ? phy_out : !hold_low);
	initial begin
		sh = 64'h0;
		pos = 64;
		rd_go = 1'h0;
		phy_oe = 1'h0;
		phy_out = 1'h1;
		rd = 16'h0000;
		last_frame = 64'h0;
		for (int i = 0; i < 32; i++) mem[i] = 16'h0000;
	end
	// Frames are found from the line alone, so a missing preamble is never excused.
	always @(posedge mdc) begin
		sh = {sh[62:0], line};
		pos = pos + 1;
		if (pos > 64 && sh[33:0] == 34'h3FFFFFFFD) pos = 34;
		if (pos == 46) begin
			rd_go = (sh[11:10] == 2'h2) && (sh[9:5] == PHY_ADDR);
			rd = mem[sh[4:0]];
		end
		if (pos == 64) begin
			last_frame = sh;
			if (sh[29:28] == 2'h1 && sh[27:23] == PHY_ADDR) mem[sh[22:18]] = sh[15:0];
		end
	end
	// Answer bits change on the falling clock so they are settled at the next rise.
	always @(negedge mdc) begin
		phy_oe = rd_go && pos >= 47 && pos < 64;
		phy_out = (pos >= 48 && pos < 64) ? rd[63 - pos] : 1'h0;
	end
endmodule : mmp_phy_model
`default_nettype wire

/* verification/tb.sv */
// Self-checking testbench for the management port.
`timescale 1ns/1ps
`default_nettype none
module tb;
	localparam logic [4:0] PHY = 5'h15;
	localparam logic [4:0] RG = 5'h0A;
	logic clk = 1'h0;
	logic rst_n;
	logic [7:0] reg_addr;
	logic reg_wr;
	logic reg_rd;
	logic [31:0] reg_wdata;
	logic [31:0] reg_rdata;
	logic reg_rvalid;
	logic serial_mgmt_clock;
	logic mgmt_data_in;
	logic mgmt_data_out;
	logic mgmt_data_oe;
	logic transceiver_link_pin;
	logic transceiver_enable_pin;
	logic mii_serial_mode;
	logic tx_clock_use_internal_system_clock;
	logic hold_low;
	logic [63:0] last_frame;
	logic [31:0] rd_val;
	logic [15:0] c;
	logic [15:0] cfg_tab [4] = '{16'hC023, 16'h40C0, 16'h8042, 16'h0081};
	int mismatches = 0;
	int n_checks = 0;

	always #5 clk = ~clk;

	mmp_top dut (
		.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.serial_mgmt_clock(serial_mgmt_clock), .mgmt_data_in(mgmt_data_in),
		.mgmt_data_out(mgmt_data_out), .mgmt_data_oe(mgmt_data_oe),
		.transceiver_link_pin(transceiver_link_pin),
		.transceiver_enable_pin(transceiver_enable_pin),
		.mii_serial_mode(mii_serial_mode), .tx_clock_use_internal_system_clock(tx_clock_use_internal_system_clock)
	);

	mmp_phy_model #(.PHY_ADDR(PHY)) phy (
		.mdc(serial_mgmt_clock), .dev_out(mgmt_data_out), .dev_oe(mgmt_data_oe),
		.hold_low(hold_low), .line(mgmt_data_in), .last_frame(last_frame)
	);

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : print_verdict

	task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'h1;
		@(negedge clk);
		reg_wr = 1'h0;
	endtask : wr

	// The answer stands for one cycle only, so it is taken at the very next falling edge.
	task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
		@(negedge clk);
		reg_addr = a;
		reg_rd = 1'h1;
		@(negedge clk);
		reg_rd = 1'h0;
		check("read answer", 64'h1, {63'h0, reg_rvalid});
		check(what, {32'h0, exp}, {32'h0, reg_rdata});
	endtask : rdc

	function automatic logic [31:0] cfg_exp(input logic [15:0] v, input logic hl, input logic lk);
		logic ln;
		ln = v[7] ? !hl : v[6];
		return {16'h0, v & 16'hC0B3} | {25'h0, ln, 2'h0, ln, lk, 2'h0};
	endfunction : cfg_exp

	// A data write in mid-frame must be ignored, so every operation tries one.
	task automatic mgmt_op(input logic [4:0] p, input logic [4:0] r, input logic [1:0] op,
		input logic resp);
		wr(mmp_pkg::ADDR_CTL, {18'h0, p, r, 2'h0, op});
		repeat (4) @(negedge clk);
		rdc("control busy", mmp_pkg::ADDR_CTL, {18'h0, p, r, 2'h0, op});
		wr(mmp_pkg::ADDR_DATA, 32'h0000FFFF);
		repeat (2600) @(negedge clk);
		rdc("control done", mmp_pkg::ADDR_CTL, {18'h0, p, r, resp, 3'h0});
	endtask : mgmt_op

	initial begin
		rst_n = 1'h0;
		reg_addr = 8'h00;
		reg_wr = 1'h0;
		reg_rd = 1'h0;
		reg_wdata = 32'h0;
		transceiver_link_pin = 1'h0;
		hold_low = 1'h0;
		repeat (5) @(negedge clk);
		rst_n = 1'h1;
		rdc("control reset", mmp_pkg::ADDR_CTL, 32'h0);
		// The released data line is pulled up, so the pin bits read one after reset.
		rdc("config reset", mmp_pkg::ADDR_CFG, cfg_exp(16'h0050, 1'h0, 1'h0));
		rdc("data reset", mmp_pkg::ADDR_DATA, 32'h0);
		rdc("unmapped", 8'h3C, 32'h0);
		$display("test reset done");
		for (int i = 0; i < 4; i++) begin
			c = cfg_tab[i];
			transceiver_link_pin = i[0];
			hold_low = (i == 3);
			wr(mmp_pkg::ADDR_CFG, {16'h0, c});
			repeat (6) @(negedge clk);
			rdc("config", mmp_pkg::ADDR_CFG, cfg_exp(c, hold_low, i[0]));
			check("pins", {58'h0, c[5], !c[7], c[6] & !c[7], c[1], c[0], c[15] & c[14]},
				{58'h0, serial_mgmt_clock, mgmt_data_oe, mgmt_data_out & mgmt_data_oe,
				transceiver_enable_pin, mii_serial_mode, tx_clock_use_internal_system_clock});
		end
		hold_low = 1'h0;
		wr(mmp_pkg::ADDR_CFG, 32'h00000010);
		$display("test direct pins done");
		wr(mmp_pkg::ADDR_DATA, 32'h00001234);
		rdc("data", mmp_pkg::ADDR_DATA, 32'h00001234);
		mgmt_op(PHY, RG, 2'h2, 1'h0);
		check("write frame", {32'hFFFFFFFF, 2'h1, 2'h1, PHY, RG, 2'h2, 16'h1234}, last_frame);
		rdc("data kept", mmp_pkg::ADDR_DATA, 32'h00001234);
		$display("test write frame done");
		wr(mmp_pkg::ADDR_DATA, 32'h0);
		mgmt_op(PHY, RG, 2'h1, 1'h1);
		rdc("responder cleared", mmp_pkg::ADDR_CTL, {18'h0, PHY, RG, 4'h0});
		check("read frame", {18'h0, 32'hFFFFFFFF, 2'h1, 2'h2, PHY, RG}, {18'h0, last_frame[63:18]});
		rdc("read data", mmp_pkg::ADDR_DATA, 32'h00001234);
		$display("test read frame done");
		mgmt_op(5'h0E, 5'h03, 2'h1, 1'h0);
		rdc("absent data", mmp_pkg::ADDR_DATA, 32'h0000FFFF);
		$display("test absent responder done");
		print_verdict;
	end
endmodule : tb
`default_nettype wire
